// ### rtl/can_filter_defs.vh
`ifndef CAN_FILTER_DEFS_VH
`define CAN_FILTER_DEFS_VH

// ----------------------------------------
// Register map (byte offsets, word index = byte/4)
// ----------------------------------------
`define ADDR_W 8
`define OFF_CTRL_12_TO_15 8'h00
`define OFF_CTRL_20_TO_23 8'h04
`define OFF_MASK0 8'h10
`define OFF_MASK1 8'h14
`define OFF_MASK2 8'h18
`define OFF_MASK3 8'h1C
`define OFF_ID_BASE 8'h20
`define OFF_RX_ID 8'h40
`define OFF_MATCH 8'h44

// ----------------------------------------
// Slot field layout within a byte
// ----------------------------------------
`define SLOT_W 8
`define SLOT_EN_BIT 7
`define SLOT_MSEL_HI 6
`define SLOT_MSEL_LO 5
`define SLOT_FSEL_HI 4
`define SLOT_FSEL_LO 0
`define SLOT_MASK 8'hFF

`define ID_W 29
`define CTRL_RESET 32'h0000_0000
`define ZERO32 32'h0000_0000

`endif

// ### rtl/slot_decode.v
`timescale 1ns/1ns
`include "can_filter_defs.vh"

// ----------------------------------------
// One filter slot: mask choice and compare
// ----------------------------------------
module slot_decode #(
    parameter ID_W = `ID_W
) (
    input wire [7:0] slot_byte,
    input wire [ID_W-1:0] rx_id,
    input wire [ID_W-1:0] filter_id,
    input wire [4*ID_W-1:0] masks,
    output wire hit,
    output wire [4:0] buffer_choice
);
    wire filter_slot_enable;
    wire [1:0] mask_choice;
    reg [ID_W-1:0] mask_sel;

    assign filter_slot_enable = slot_byte[`SLOT_EN_BIT];
    assign mask_choice = slot_byte[`SLOT_MSEL_HI:`SLOT_MSEL_LO];
    assign buffer_choice = slot_byte[`SLOT_FSEL_HI:`SLOT_FSEL_LO];

    always @* begin
        case (mask_choice)
            2'h0: mask_sel = masks[ID_W-1:0];
            2'h1: mask_sel = masks[2*ID_W-1:ID_W];
            2'h2: mask_sel = masks[3*ID_W-1:2*ID_W];
            2'h3: mask_sel = masks[4*ID_W-1:3*ID_W];
            default: mask_sel = masks[ID_W-1:0];
        endcase
    end

    // Disabled slot never matches
    assign hit = filter_slot_enable &
        (((rx_id ^ filter_id) & mask_sel) == {ID_W{1'b0}});
endmodule // slot_decode

// ### rtl/ctrl_word.v
`timescale 1ns/1ns
`include "can_filter_defs.vh"

// ----------------------------------------
// Control word of four slots with lock
// ----------------------------------------
module ctrl_word (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire wr,
    input wire [31:0] wdata,
    output reg [31:0] word_reg
);
    reg [31:0] word_next;
    integer i;

    always @* begin
        word_next = word_reg;
        if (wr) begin
            for (i = 0; i < 4; i = i + 1) begin
                // Fields held while slot enabled; enable itself free
                if (!word_reg[i*`SLOT_W+`SLOT_EN_BIT])
                    word_next[i*`SLOT_W +: `SLOT_W] =
                        wdata[i*`SLOT_W +: `SLOT_W];
                else
                    word_next[i*`SLOT_W+`SLOT_EN_BIT] =
                        wdata[i*`SLOT_W+`SLOT_EN_BIT];
            end
        end
    end

    always @(posedge clk) begin
        if (rst)
            word_reg <= `CTRL_RESET;
        else if (ce)
            word_reg <= word_next;
    end
endmodule // ctrl_word

// ### rtl/can_filter_ctrl.v
// Notes on behaviour
// - A slot takes part in filtering only while its enable bit is 1.
// - Mask select 00..11 applies acceptance mask 0..3.
// - A match steers the message to the buffer named by the 5-bit field.
// - Mask and buffer fields change only while the slot is disabled.
// - Filter 15 sits in bits 31..24 of the 12-15 word.
// - Filter 14 sits in bits 23..16 of the 12-15 word.
// - Filter 23 sits in bits 31..24 of the 20-23 word.
// - Filter 22 sits in bits 23..16, lower filters lower bytes.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "can_filter_defs.vh"

module can_filter_ctrl #(
    parameter ID_W = `ID_W
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [`ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire rx_valid,
    input wire [ID_W-1:0] rx_id_in,
    output reg match_valid,
    output reg [4:0] match_buffer,
    output reg [4:0] match_filter
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    wire [31:0] ctrl_lo_reg;
    wire [31:0] ctrl_hi_reg;
    reg [ID_W-1:0] mask_reg [0:3];
    reg [ID_W-1:0] id_reg [0:7];
    reg [ID_W-1:0] last_id_reg;
    reg [4:0] last_filter_reg;
    reg last_hit_reg;
    integer k;

    ctrl_word u_lo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr(wr && addr == `OFF_CTRL_12_TO_15),
        .wdata(wdata),
        .word_reg(ctrl_lo_reg)
    );

    ctrl_word u_hi (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr(wr && addr == `OFF_CTRL_20_TO_23),
        .wdata(wdata),
        .word_reg(ctrl_hi_reg)
    );

    // Slot bytes: index 0..3 = filters 12..15, 4..7 = filters 20..23
    wire [63:0] slots;
    assign slots = {ctrl_hi_reg, ctrl_lo_reg};

    wire [4*ID_W-1:0] masks;
    assign masks = {mask_reg[3], mask_reg[2], mask_reg[1], mask_reg[0]};

    function is_id_addr;
        input [`ADDR_W-1:0] a;
        is_id_addr = (a >= `OFF_ID_BASE) && (a < `OFF_RX_ID)
            && (a[1:0] == 2'b00);
    endfunction

    function [2:0] id_index;
        input [`ADDR_W-1:0] a;
        id_index = a[4:2];
    endfunction

    // ----------------------------------------
    // Mask and identifier registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            for (k = 0; k < 4; k = k + 1)
                mask_reg[k] <= {ID_W{1'b0}};
            for (k = 0; k < 8; k = k + 1)
                id_reg[k] <= {ID_W{1'b0}};
        end else if (ce && wr) begin
            if (addr == `OFF_MASK0)
                mask_reg[0] <= wdata[ID_W-1:0];
            if (addr == `OFF_MASK1)
                mask_reg[1] <= wdata[ID_W-1:0];
            if (addr == `OFF_MASK2)
                mask_reg[2] <= wdata[ID_W-1:0];
            if (addr == `OFF_MASK3)
                mask_reg[3] <= wdata[ID_W-1:0];
            // Identifier locked like the slot fields
            if (is_id_addr(addr) &&
                !slots[id_index(addr)*8+`SLOT_EN_BIT])
                id_reg[id_index(addr)] <= wdata[ID_W-1:0];
        end
    end

    // ----------------------------------------
    // Per-slot compare
    // ----------------------------------------
    wire [7:0] hits;
    wire [39:0] bufs;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_slot
            slot_decode #(.ID_W(ID_W)) u_slot (
                .slot_byte(slots[g*8 +: 8]),
                .rx_id(rx_id_in),
                .filter_id(id_reg[g]),
                .masks(masks),
                .hit(hits[g]),
                .buffer_choice(bufs[g*5 +: 5])
            );
        end
    endgenerate

    // Lowest filter number wins when several match
    reg any_hit;
    reg [2:0] win;
    integer j;
    always @* begin
        any_hit = 1'b0;
        win = 3'd0;
        for (j = 7; j >= 0; j = j - 1) begin
            if (hits[j]) begin
                any_hit = 1'b1;
                win = j[2:0];
            end
        end
    end

    function [4:0] filter_number;
        input [2:0] s;
        filter_number = s[2] ? (5'd20 + {3'b000, s[1:0]})
                             : (5'd12 + {3'b000, s[1:0]});
    endfunction

    // ----------------------------------------
    // Match result
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            match_valid <= 1'b0;
            match_buffer <= 5'h00;
            match_filter <= 5'h00;
            last_id_reg <= {ID_W{1'b0}};
            last_filter_reg <= 5'h00;
            last_hit_reg <= 1'b0;
        end else if (ce) begin
            match_valid <= rx_valid && any_hit;
            if (rx_valid) begin
                last_id_reg <= rx_id_in;
                last_hit_reg <= any_hit;
                if (any_hit) begin
                    match_buffer <= bufs[win*5 +: 5];
                    match_filter <= filter_number(win);
                    last_filter_reg <= filter_number(win);
                end
            end
        end
    end

    // ----------------------------------------
    // Read port, data one cycle after strobe
    // ----------------------------------------
    reg [31:0] rmux;
    always @* begin
        rmux = `ZERO32;
        case (addr)
            `OFF_CTRL_12_TO_15: rmux = ctrl_lo_reg;
            `OFF_CTRL_20_TO_23: rmux = ctrl_hi_reg;
            `OFF_MASK0: rmux[ID_W-1:0] = mask_reg[0];
            `OFF_MASK1: rmux[ID_W-1:0] = mask_reg[1];
            `OFF_MASK2: rmux[ID_W-1:0] = mask_reg[2];
            `OFF_MASK3: rmux[ID_W-1:0] = mask_reg[3];
            `OFF_RX_ID: rmux[ID_W-1:0] = last_id_reg;
            `OFF_MATCH: rmux = {26'h000_0000, last_hit_reg,
                                last_filter_reg};
            default: begin
                if (is_id_addr(addr))
                    rmux[ID_W-1:0] = id_reg[id_index(addr)];
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst)
            rdata <= `ZERO32;
        else if (ce)
            rdata <= rd ? rmux : `ZERO32;
    end
endmodule // can_filter_ctrl

// ### test/can_filter_chk.sv
`timescale 1ns/1ns
// ------------
// Port checker
// ------------
module can_filter_chk (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire wr,
    input wire rd,
    input wire ce,
    input wire [31:0] rdata,
    input wire rx_valid,
    input wire match_valid,
    input wire [4:0] match_buffer,
    input wire [4:0] match_filter
);
    reg en_seen;
    // Until a control word is written no slot can be on
    always @(posedge clk) begin
        if (rst) en_seen <= 1'b0;
        else if (ce && wr && addr < 8'h08) en_seen <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property ($past(ce) && !$past(rd) |->
        rdata == 32'h0000_0000) else $error("rdata not zero");
    chk_unmapped_zero: assert property ($past(rd) &&
        $past(addr) >= 8'h48 |-> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_match_cause: assert property (match_valid |->
        $past(rx_valid) && $past(ce)) else $error("match without id");
    chk_filter_range: assert property (match_valid |->
        (match_filter >= 5'h0C && match_filter <= 5'h0F) ||
        (match_filter >= 5'h14 && match_filter <= 5'h17))
        else $error("bad filter number");
    chk_buffer_hold: assert property (!match_valid |->
        $stable(match_buffer)) else $error("buffer moved");
    chk_filter_hold: assert property (!match_valid |->
        $stable(match_filter)) else $error("filter moved");
    chk_none_enabled: assert property (!en_seen |->
        !match_valid) else $error("match while all off");
    chk_reset_clear: assert property ($past(rst) |->
        rdata == 32'h0000_0000 && !match_valid && match_buffer == 5'h0)
        else $error("outputs not clear after reset");
    cover property (match_valid);
    cover property ($past(rd) && rdata != 32'h0000_0000);
    cover property (rx_valid ##1 !match_valid);
endmodule // can_filter_chk

bind can_filter_ctrl can_filter_chk chk_u (.clk(clk), .rst(rst),
    .addr(addr), .wr(wr), .rd(rd), .ce(ce), .rdata(rdata),
    .rx_valid(rx_valid), .match_valid(match_valid),
    .match_buffer(match_buffer), .match_filter(match_filter));

// ### test/can_rx_source.sv
`timescale 1ns/1ns
// ----------------------
// Received id source
// ----------------------
module can_rx_source (
    input wire clk,
    output logic rx_valid,
    output logic [28:0] rx_id_in
);
    initial begin
        rx_valid = 1'b0;
        rx_id_in = 29'h0000_0000;
    end
    // Idle id is inverted so a stale value is never mistaken for data
    task send(input logic [28:0] id);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id_in <= id;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_id_in <= ~id;
    endtask
endmodule // can_rx_source

// ### test/can_acceptance_filter_control_bench.sv
`timescale 1ns/1ns
module can_acceptance_filter_control_bench;
    logic clk, rst, ce, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    wire [31:0] rdata;
    wire rx_valid, match_valid;
    wire [28:0] rx_id_in;
    wire [4:0] match_buffer, match_filter;
    int n_errors = 0;
    int n_tests = 0;
    can_filter_ctrl #(.ID_W(29)) dut_u (.clk(clk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_valid(rx_valid), .rx_id_in(rx_id_in),
        .match_valid(match_valid), .match_buffer(match_buffer),
        .match_filter(match_filter));
    can_rx_source src_u (.clk(clk), .rx_valid(rx_valid),
        .rx_id_in(rx_id_in));
    // -----------
    // Bus tasks
    // -----------
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task mt(input logic [28:0] id, input logic h, input logic [4:0] b,
            input logic [4:0] f);
        src_u.send(id);
        #1;
        if (h) chk({21'h0, match_valid, match_buffer, match_filter},
                   {21'h0, h, b, f});
        else chk({31'h0, match_valid}, 32'h0000_0000);
    endtask
    task end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // -----------
    // Tests
    // -----------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    initial begin
        {rst, ce, wr, rd, addr, wdata} = {1'b1, 1'b1, 42'h0};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h00, 32'h0000_0000);
        rd_chk(8'h04, 32'h0000_0000);
        wr_reg(8'h80, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0000_0000);
        mt(29'h0000_0000, 1'b0, 5'h0, 5'h0);
        $display("Reset test done");
        // Masks and ids set while every slot is off
        wr_reg(8'h10, 32'h1FFF_FFFF);
        wr_reg(8'h14, 32'h0000_0FFF);
        wr_reg(8'h18, 32'h0000_0000);
        wr_reg(8'h1C, 32'h0000_00FF);
        wr_reg(8'h28, 32'h0000_0456);
        wr_reg(8'h2C, 32'h0000_0123);
        wr_reg(8'h00, 32'hBFE5_0000);
        wr_reg(8'h04, 32'h90CA_0000);
        rd_chk(8'h00, 32'hBFE5_0000);
        rd_chk(8'h04, 32'h90CA_0000);
        mt(29'h1000_0123, 1'b1, 5'h1F, 5'h0F);
        mt(29'h00AB_CD56, 1'b1, 5'h05, 5'h0E);
        mt(29'h0000_0777, 1'b1, 5'h0A, 5'h16);
        $display("Layout test done");
        wr_reg(8'h04, 32'h80CB_0000);
        rd_chk(8'h04, 32'h90CA_0000);
        wr_reg(8'h04, 32'h0000_0000);
        rd_chk(8'h04, 32'h104A_0000);
        wr_reg(8'h3C, 32'h0000_0777);
        wr_reg(8'h04, 32'h9000_0000);
        rd_chk(8'h04, 32'h9000_0000);
        mt(29'h0000_0777, 1'b1, 5'h10, 5'h17);
        mt(29'h0000_0778, 1'b0, 5'h0, 5'h0);
        wr_reg(8'h3C, 32'h0000_0555);
        rd_chk(8'h3C, 32'h0000_0777);
        rd_chk(8'h2C, 32'h0000_0123);
        rd_chk(8'h40, 32'h0000_0778);
        rd_chk(8'h44, 32'h0000_0017);
        $display("Lock test done");
        // Clock enable low: write and received id both ignored
        @(posedge clk) ce <= 1'b0;
        wr_reg(8'h04, 32'h0000_0000);
        mt(29'h0000_0777, 1'b0, 5'h0, 5'h0);
        @(posedge clk) ce <= 1'b1;
        rd_chk(8'h04, 32'h9000_0000);
        mt(29'h0000_0777, 1'b1, 5'h10, 5'h17);
        $display("Enable test done");
        end_of_test;
    end
endmodule // can_acceptance_filter_control_bench
